// file: rtl/tcd_dma.v
`timescale 1ns/1ps
`include "tcd_consts.vh"

// What this block does
// - Two channels, each started by its own request line or software trigger.
// - Only one channel moves data at a time, chosen by priority.
// - Two-bit priority per channel, 00 low up to 11 very high wins.
// - Memory-to-memory channels ignore their peripheral request line.
// - Items may be 8, 16 or 32 bits wide.
// - Source and destination addresses each stay fixed or step per item.
// - Any direction allowed; endpoints are only addresses to the engine.
// - Configuration bit 15 picks single or burst transfers.
// - Single mode: one request per item, count drops by one, ends at zero.
// - Single mode ignores the burst field and moves one item.
// - Burst mode: one request runs bursts, count drops by one per item, ends at zero.
// - Without loop mode a finished channel accepts no more requests.
// - Loop mode reloads the initial count on completion and keeps serving.
// - Engine starts new accesses only while the controller clock gate is set; an access already in flight still completes.
module tcd_dma (
  input  wire        clk,                     // System bus clock, 200 MHz
  input  wire        rst_b,                   // Synchronous reset, active low
  input  wire        controller_clock_gate,   // Controller enable from bus config
  input  wire [1:0]  ch_enable,               // Channel enable per channel
  input  wire [31:0] channel_config_register, // Config words, channel 1 high
  input  wire [1:0]  count_load,              // Pulse: load count and addresses
  input  wire [63:0] count_init,              // Initial count, channel 1 high
  input  wire [63:0] src_addr_init,           // Start source address
  input  wire [63:0] dst_addr_init,           // Start destination address
  input  wire [1:0]  periph_req,              // Peripheral request lines
  input  wire [1:0]  sw_trigger,              // Software request pulses
  input  wire [1:0]  done_clear,              // Pulse: clear done flag
  output reg         bus_req,                 // Bus access requested
  output reg         bus_we,                  // Access is a write
  output reg  [31:0] bus_addr,                // Access address
  output reg  [1:0]  bus_size,                // Access size code
  output reg  [31:0] bus_wdata,               // Write data
  input  wire        bus_ack,                 // Access finished
  input  wire [31:0] bus_rdata,               // Read data on ack
  output reg  [63:0] remaining_item_count,    // Live count, channel 1 high
  output reg  [1:0]  transfer_done,           // Sticky completion flags
  output reg         busy,                    // A transfer is running
  output reg         active_ch                // Channel being served
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RD   = 3'h1;
  localparam ST_RD_W = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_WR_W = 3'h4;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [2:0]  rd_left_r;
  reg  [2:0]  wr_left_r;
  reg  [1:0]  pend_r;
  reg  [63:0] init_r;
  reg  [63:0] src_r;
  reg  [63:0] dst_r;
  wire        grant_valid;
  wire        grant_ch;
  wire [3:0]  prio;
  wire [1:0]  burst_mode;
  wire [1:0]  loop_mode;
  wire [5:0]  burst_len;
  wire [3:0]  item_size;
  wire [1:0]  src_inc;
  wire [1:0]  dst_inc;
  wire [1:0]  m2m;
  wire        rd_ack;
  wire        wr_ack;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire        fifo_pop;
  reg  [2:0]  first_len;

  assign rd_ack   = (state_r == ST_RD_W) && bus_ack;
  assign wr_ack   = (state_r == ST_WR_W) && bus_ack;
  assign fifo_pop = (state_r == ST_WR) && controller_clock_gate && fifo_out_valid;

  genvar i;
  generate
    for (i = 0; i < `TCD_NCH; i = i + 1) begin : g_ch
      wire [15:0] cfg;
      wire [2:0]  bfield;
      wire [31:0] step;
      wire        mine;
      wire        last;
      wire        req_in;
      assign cfg    = channel_config_register[16*i+15:16*i];
      assign bfield = cfg[`TCD_CFG_BURST_MSB:`TCD_CFG_BURST_LSB];
      assign prio[2*i+1:2*i]      = cfg[`TCD_CFG_PRIO_MSB:`TCD_CFG_PRIO_LSB];
      assign burst_mode[i]        = (cfg[`TCD_CFG_TYPE_BIT] == `TCD_TYPE_BURST);
      assign loop_mode[i]         = cfg[`TCD_CFG_LOOP_BIT];
      assign burst_len[3*i+2:3*i] = (!burst_mode[i] || bfield == 3'h0) ? 3'h1 : bfield;
      assign item_size[2*i+1:2*i] = cfg[`TCD_CFG_SIZE_MSB:`TCD_CFG_SIZE_LSB];
      assign step = (item_size[2*i+1:2*i] == `TCD_SIZE_BYTE) ? 32'h0000_0001 :
                    (item_size[2*i+1:2*i] == `TCD_SIZE_HALF) ? 32'h0000_0002 :
                    32'h0000_0004;
      assign src_inc[i] = cfg[`TCD_CFG_SRC_INC_BIT];
      assign dst_inc[i] = cfg[`TCD_CFG_DST_INC_BIT];
      assign m2m[i]     = cfg[`TCD_CFG_M2M_BIT];
      assign mine       = (active_ch == (i != 0));
      assign last       = wr_ack && mine &&
                          (remaining_item_count[32*i+31:32*i] == 32'h0000_0001);
      assign req_in = sw_trigger[i] | (periph_req[i] & ~m2m[i]);

      always @(posedge clk) begin
        if (!rst_b) begin
          remaining_item_count[32*i+31:32*i] <= `TCD_CNT_RESET;
          init_r[32*i+31:32*i]               <= `TCD_CNT_RESET;
          src_r[32*i+31:32*i]                <= `TCD_ADDR_RESET;
          dst_r[32*i+31:32*i]                <= `TCD_ADDR_RESET;
          pend_r[i]                          <= 1'b0;
          transfer_done[i]                   <= 1'b0;
        end else begin
          if (count_load[i]) begin
            remaining_item_count[32*i+31:32*i] <= count_init[32*i+31:32*i];
            init_r[32*i+31:32*i]               <= count_init[32*i+31:32*i];
            src_r[32*i+31:32*i]                <= src_addr_init[32*i+31:32*i];
            dst_r[32*i+31:32*i]                <= dst_addr_init[32*i+31:32*i];
          end else begin
            if (rd_ack && mine && src_inc[i]) begin
              src_r[32*i+31:32*i] <= src_r[32*i+31:32*i] + step;
            end
            if (wr_ack && mine) begin
              remaining_item_count[32*i+31:32*i] <=
                remaining_item_count[32*i+31:32*i] - 32'h0000_0001;
              if (dst_inc[i]) begin
                dst_r[32*i+31:32*i] <= dst_r[32*i+31:32*i] + step;
              end
            end
            if (last && loop_mode[i]) begin
              remaining_item_count[32*i+31:32*i] <= init_r[32*i+31:32*i];
              src_r[32*i+31:32*i] <= src_addr_init[32*i+31:32*i];
              dst_r[32*i+31:32*i] <= dst_addr_init[32*i+31:32*i];
            end
          end
          // only while count remains; set beats clear
          if (req_in && ch_enable[i] &&
              remaining_item_count[32*i+31:32*i] != 32'h0000_0000) begin
            pend_r[i] <= 1'b1;
          end else if (!ch_enable[i] || last ||
                       (wr_ack && mine && wr_left_r == 3'h1 && !burst_mode[i])) begin
            pend_r[i] <= 1'b0;
          end
          if (last) begin
            transfer_done[i] <= 1'b1;
          end else if (done_clear[i]) begin
            transfer_done[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  tcd_arb u_arb (
    .pend        (pend_r),
    .prio        (prio),
    .grant_valid (grant_valid),
    .grant_ch    (grant_ch)
  );

  tcd_fifo #(
    .WIDTH (`TCD_DW),
    .DEPTH (`TCD_FIFO_DEPTH),
    .PW    (`TCD_FIFO_PW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rd_ack),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Burst clipped to what is left so the count never wraps
  always @* begin
    first_len = grant_ch ? burst_len[5:3] : burst_len[2:0];
    if (grant_ch) begin
      if (remaining_item_count[63:32] < {29'h0000_0000, first_len}) begin
        first_len = remaining_item_count[34:32];
      end
    end else begin
      if (remaining_item_count[31:0] < {29'h0000_0000, first_len}) begin
        first_len = remaining_item_count[2:0];
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (controller_clock_gate && grant_valid) begin
          state_nxt = ST_RD;
        end
      end
      ST_RD: begin
        if (controller_clock_gate && fifo_in_ready) begin
          state_nxt = ST_RD_W;
        end
      end
      ST_RD_W: begin
        if (bus_ack) begin
          state_nxt = (rd_left_r == 3'h1) ? ST_WR : ST_RD;
        end
      end
      ST_WR: begin
        if (controller_clock_gate && fifo_out_valid) begin
          state_nxt = ST_WR_W;
        end
      end
      ST_WR_W: begin
        if (bus_ack) begin
          state_nxt = (wr_left_r == 3'h1) ? ST_IDLE : ST_WR;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      rd_left_r <= 3'h0;
      wr_left_r <= 3'h0;
      active_ch <= 1'b0;
      busy      <= 1'b0;
      bus_req   <= 1'b0;
      bus_we    <= 1'b0;
      bus_addr  <= `TCD_ADDR_RESET;
      bus_size  <= `TCD_SIZE_BYTE;
      bus_wdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      busy    <= (state_nxt != ST_IDLE);
      case (state_r)
        ST_IDLE: begin
          if (controller_clock_gate && grant_valid) begin
            active_ch <= grant_ch;
            rd_left_r <= first_len;
            wr_left_r <= first_len;
          end
        end
        ST_RD: begin
          if (controller_clock_gate && fifo_in_ready) begin
            bus_req  <= 1'b1;
            bus_we   <= 1'b0;
            bus_addr <= active_ch ? src_r[63:32] : src_r[31:0];
            bus_size <= active_ch ? item_size[3:2] : item_size[1:0];
          end
        end
        ST_RD_W: begin
          if (bus_ack) begin
            bus_req   <= 1'b0;
            rd_left_r <= rd_left_r - 3'h1;
          end
        end
        ST_WR: begin
          if (controller_clock_gate && fifo_out_valid) begin
            bus_req   <= 1'b1;
            bus_we    <= 1'b1;
            bus_addr  <= active_ch ? dst_r[63:32] : dst_r[31:0];
            bus_wdata <= fifo_out_data;
          end
        end
        ST_WR_W: begin
          if (bus_ack) begin
            bus_req   <= 1'b0;
            bus_we    <= 1'b0;
            wr_left_r <= wr_left_r - 3'h1;
          end
        end
        default: begin
          bus_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // tcd_dma

// file: rtl/tcd_consts.vh
`ifndef TCD_CONSTS_VH
`define TCD_CONSTS_VH

// Channel configuration word layout
`define TCD_CFG_W           16
`define TCD_CFG_TYPE_BIT    15
`define TCD_CFG_BURST_MSB   14
`define TCD_CFG_BURST_LSB   12
`define TCD_CFG_SIZE_MSB    11
`define TCD_CFG_SIZE_LSB    10
`define TCD_CFG_SRC_INC_BIT 9
`define TCD_CFG_DST_INC_BIT 8
`define TCD_CFG_LOOP_BIT    7
`define TCD_CFG_M2M_BIT     6
`define TCD_CFG_PRIO_MSB    5
`define TCD_CFG_PRIO_LSB    4
`define TCD_CFG_RESET       16'h0000

// Transfer type values
`define TCD_TYPE_SINGLE     1'b0
`define TCD_TYPE_BURST      1'b1

// Data item size codes
`define TCD_SIZE_BYTE       2'h0
`define TCD_SIZE_HALF       2'h1
`define TCD_SIZE_WORD       2'h2

// Priority levels
`define TCD_PRIO_LOW        2'h0
`define TCD_PRIO_MEDIUM     2'h1
`define TCD_PRIO_HIGH       2'h2
`define TCD_PRIO_VHIGH      2'h3

// Channel and datapath sizes
`define TCD_NCH             2
`define TCD_AW              32
`define TCD_DW              32
`define TCD_CW              32
`define TCD_FIFO_DEPTH      16
`define TCD_FIFO_PW         4

// Reset values
`define TCD_CNT_RESET       32'h0000_0000
`define TCD_ADDR_RESET      32'h0000_0000

`endif

// file: rtl/tcd_fifo.v
`timescale 1ns/1ps
`include "tcd_consts.vh"

module tcd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  input  wire             clk,        // System clock
  input  wire             rst_b,      // Synchronous reset, active low
  input  wire             in_valid,   // Write side offers a word
  output wire             in_ready,   // Room for a word
  input  wire [WIDTH-1:0] in_data,    // Word written
  output wire             out_valid,  // A word is waiting
  input  wire             out_ready,  // Read side takes the word
  output wire [WIDTH-1:0] out_data    // Head word
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [WIDTH-1:0] head_r;
  reg [PW-1:0]    wr_ptr_r;
  reg [PW-1:0]    rd_ptr_r;
  reg [PW:0]      fill_r;
  wire            push;
  wire            pop;

  assign in_ready  = (fill_r != DEPTH[PW:0]);
  assign out_valid = (fill_r != {(PW+1){1'b0}});
  assign out_data  = head_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Head word is registered; a push into an empty or draining FIFO lands there directly
  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
    if (push && (fill_r == {(PW+1){1'b0}} ||
                 (pop && fill_r == {{PW{1'b0}}, 1'b1}))) begin
      head_r <= in_data;
    end else if (pop) begin
      head_r <= mem_r[rd_ptr_r + 1'b1];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_r <= {PW{1'b0}};
      rd_ptr_r <= {PW{1'b0}};
      fill_r   <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        fill_r <= fill_r + 1'b1;
      end else if (pop && !push) begin
        fill_r <= fill_r - 1'b1;
      end
    end
  end

endmodule // tcd_fifo

// file: rtl/tcd_arb.v
`timescale 1ns/1ps
`include "tcd_consts.vh"

module tcd_arb (
  input  wire [1:0] pend,        // Pending request per channel
  input  wire [3:0] prio,        // Two-bit priority per channel
  output reg        grant_valid, // Some channel may run
  output reg        grant_ch     // Winning channel
);

  always @* begin
    grant_valid = pend[0] | pend[1];
    grant_ch    = 1'b0;
    if (pend[1] && (!pend[0] || (prio[3:2] > prio[1:0]))) begin
      grant_ch = 1'b1;
    end
  end

endmodule // tcd_arb

// file: sim/tcd_mem_model.sv
`timescale 1ns/1ps
module tcd_mem_model (
  input  wire        clk,   // System clock
  input  wire        req,   // Access pending
  input  wire        we,    // Write access
  input  wire [31:0] addr,  // Access address
  input  wire [1:0]  size,  // Size code
  input  wire [31:0] wdata, // Write data
  input  wire [3:0]  lat,   // Wait cycles before ack
  output reg         ack,   // One-cycle completion
  output reg  [31:0] rdata  // Read data
);
  reg [3:0]  wait_r;
  reg [31:0] wr_addr [0:63];
  reg [31:0] wr_data [0:63];
  reg [1:0]  wr_size [0:63];
  integer    n_wr;
  initial begin
    ack = 1'b0;
    rdata = 32'h0;
    wait_r = 4'h0;
    n_wr = 0;
  end
  // Read data toggles outside acks so stale values never match
  always @(posedge clk) begin
    rdata <= ~rdata;
    if (ack || !req) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r >= lat) begin
      ack <= 1'b1;
      if (!we) begin
        rdata <= {addr[15:0], ~addr[15:0]};
      end else begin
        wr_addr[n_wr] <= addr;
        wr_data[n_wr] <= wdata;
        wr_size[n_wr] <= size;
        n_wr <= n_wr + 1;
      end
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // tcd_mem_model

// file: sim/tcd_dma_chk.sv
`timescale 1ns/1ps
module tcd_dma_chk (
  input wire        clk,                     // Clock
  input wire        rst_b,                   // Reset
  input wire        controller_clock_gate,   // Engine enable
  input wire [1:0]  ch_enable,               // Enables
  input wire [31:0] channel_config_register, // Config
  input wire [1:0]  count_load,              // Loads
  input wire [63:0] count_init,              // Initial counts
  input wire [1:0]  periph_req,              // Peripheral requests
  input wire [1:0]  sw_trigger,              // Software requests
  input wire [1:0]  done_clear,              // Done clears
  input wire        bus_req,                 // Access pending
  input wire        bus_we,                  // Write
  input wire [31:0] bus_addr,                // Address
  input wire        bus_ack,                 // Ack
  input wire [63:0] remaining_item_count,    // Counts
  input wire [1:0]  transfer_done,           // Done flags
  input wire        busy,                    // Busy
  input wire        active_ch                // Served channel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_done;
    bus_req && bus_we && bus_ack;
  endsequence
  sequence s_quiet;
    !busy && controller_clock_gate && sw_trigger == 2'h0 && (periph_req & ch_enable &
      ~{channel_config_register[22], channel_config_register[6]}) == 2'h0;
  endsequence
  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(active_ch);
  endproperty
  a_hold: assert property (p_hold) else $error("access changed before ack");
  property p_gap;
    bus_req && bus_ack |=> !bus_req;
  endproperty
  a_gap: assert property (p_gap) else $error("request held after ack");
  property p_gate;
    (!controller_clock_gate && !busy) ##1 !controller_clock_gate [*3] |-> !$rose(bus_req);
  endproperty
  a_gate: assert property (p_gate) else $error("access started with gate low");
  property p_quiet;
    s_quiet ##1 s_quiet |=> !busy && !bus_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("access without request");
  property p_step;
    s_wr_done ##0 (!active_ch && count_load == 2'h0 && !channel_config_register[15] &&
      remaining_item_count[31:0] > 32'h1) |=> remaining_item_count[31:0] ==
      $past(remaining_item_count[31:0]) - 32'h1;
  endproperty
  a_step: assert property (p_step) else $error("count did not drop by one");
  property p_done;
    $rose(transfer_done[0]) |-> $past(bus_we) && $past(bus_ack);
  endproperty
  a_done: assert property (p_done) else $error("done without final write");
  property p_clear;
    transfer_done[0] && done_clear[0] && !bus_ack |=> !transfer_done[0];
  endproperty
  a_clear: assert property (p_clear) else $error("done flag not cleared");
  property p_stop;
    $rose(transfer_done[0]) && !channel_config_register[7] |-> remaining_item_count[31:0] == 0;
  endproperty
  a_stop: assert property (p_stop) else $error("count not zero at done");
  property p_reload;
    $rose(transfer_done[0]) && channel_config_register[7] |->
      remaining_item_count[31:0] == $past(count_init[31:0]);
  endproperty
  a_reload: assert property (p_reload) else $error("loop count not reloaded");
endmodule // tcd_dma_chk

bind tcd_dma tcd_dma_chk chk_u (.clk, .rst_b, .controller_clock_gate, .ch_enable,
  .channel_config_register, .count_load, .count_init, .periph_req, .sw_trigger, .done_clear,
  .bus_req, .bus_we, .bus_addr, .bus_ack, .remaining_item_count, .transfer_done, .busy,
  .active_ch);

// file: sim/test_tcd_dma.sv
`timescale 1ns/1ps
module test_tcd_dma;
  reg clk, rst_b, gate;
  reg [1:0] ch_enable, count_load, periph_req, sw_trigger, done_clear;
  reg [31:0] cfg;
  reg [63:0] cnt_i, src_i, dst_i;
  reg [3:0] lat;
  wire bus_req, bus_we, bus_ack, busy, act;
  wire [1:0] bus_size, done;
  wire [31:0] bus_addr, bus_wdata, bus_rdata;
  wire [63:0] rem;
  integer mismatches, n_compared, k, j, n0;
  tcd_dma dut_u (.clk(clk), .rst_b(rst_b), .controller_clock_gate(gate), .ch_enable(ch_enable),
    .channel_config_register(cfg), .count_load(count_load), .count_init(cnt_i),
    .src_addr_init(src_i), .dst_addr_init(dst_i), .periph_req(periph_req),
    .sw_trigger(sw_trigger), .done_clear(done_clear), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .remaining_item_count(rem), .transfer_done(done), .busy(busy),
    .active_ch(act));
  tcd_mem_model mem_u (.clk(clk), .req(bus_req), .we(bus_we), .addr(bus_addr),
    .size(bus_size), .wdata(bus_wdata), .lat(lat), .ack(bus_ack), .rdata(bus_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task stop_test;
    begin
      if (mismatches == 0 && n_compared > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task check(input string what, input [63:0] exp, input [63:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // Load count first, enable after; no flash or core addresses are used
  task setup(input integer ch, input [15:0] c, input [31:0] n);
    begin
      @(negedge clk);
      cfg[ch*16 +: 16] = c;
      cnt_i[ch*32 +: 32] = n;
      count_load[ch] = 1'b1;
      @(negedge clk);
      count_load = 2'h0;
      ch_enable[ch] = 1'b1;
      check("count", n, rem[ch*32 +: 32]);
    end
  endtask
  task trig(input [1:0] m);
    begin
      @(negedge clk);
      sw_trigger = m;
      @(negedge clk);
      sw_trigger = 2'h0;
    end
  endtask
  task wait_wr(input integer t);
    begin
      j = 0;
      while (mem_u.n_wr < t && j < 500) begin
        @(negedge clk);
        j = j + 1;
      end
      repeat (2) @(negedge clk);
      check("writes", t, mem_u.n_wr);
    end
  endtask
  task wait_done(input integer ch);
    begin
      j = 0;
      while (done[ch] !== 1'b1 && j < 500) begin
        @(negedge clk);
        j = j + 1;
      end
      check("done", 1, done[ch]);
      done_clear[ch] = 1'b1;
      @(negedge clk);
      done_clear = 2'h0;
      @(negedge clk);
      check("done clear", 0, done[ch]);
    end
  endtask
  task chkwr(input integer i, input [31:0] a, input [31:0] s, input [1:0] z);
    begin
      check("wr addr", a, mem_u.wr_addr[i]);
      check("wr size", z, mem_u.wr_size[i]);
      check("wr data", {s[15:0], ~s[15:0]} & ~(32'hFFFFFFFF << (8 << z)),
        mem_u.wr_data[i] & ~(32'hFFFFFFFF << (8 << z)));
    end
  endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    rst_b = 1'b0; gate = 1'b1; lat = 4'h0; cfg = 32'h0; cnt_i = 64'h0;
    ch_enable = 2'h0; count_load = 2'h0; periph_req = 2'h0; sw_trigger = 2'h0;
    done_clear = 2'h0; src_i = {32'h1100, 32'h100}; dst_i = {32'h2400, 32'h200};
    mismatches = 0; n_compared = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    for (k = 0; k < 3; k = k + 1) begin
      n0 = mem_u.n_wr;
      setup(0, {4'h7, k[1:0], 10'h300}, 32'h2);
      trig(2'h1);
      wait_wr(n0 + 1);
      check("count", 1, rem[31:0]);
      trig(2'h1);
      wait_done(0);
      for (j = 0; j < 2; j = j + 1) begin
        chkwr(n0 + j, 32'h200 + (j << k), 32'h100 + (j << k), k);
      end
    end
    // Bursts of two items over a count of five: the last burst is clipped to one
    lat = 4'h3;
    n0 = mem_u.n_wr;
    setup(1, 16'hA900, 32'h5);
    trig(2'h2);
    wait_done(1);
    check("end count", 0, rem[63:32]);
    for (k = 0; k < 5; k = k + 1) begin
      chkwr(n0 + k, 32'h2400 + 4 * k, 32'h1100, 2'h2);
    end
    trig(2'h2);
    repeat (20) @(negedge clk);
    check("refused", n0 + 5, mem_u.n_wr);
    for (k = 0; k < 2; k = k + 1) begin
      lat = k * 2;
      n0 = mem_u.n_wr;
      setup(0, k ? 16'h9B30 : 16'h9B00, 32'h2);
      setup(1, k ? 16'h9B00 : 16'h9B30, 32'h2);
      trig(2'h3);
      wait_done(0);
      wait_done(1);
      check("winner", k ? 32'h200 : 32'h2400, mem_u.wr_addr[n0]);
      check("loser", k ? 32'h2400 : 32'h200, mem_u.wr_addr[n0 + 2]);
      check("last ch", k, act);
    end
    n0 = mem_u.n_wr;
    setup(0, 16'h0B80, 32'h2);
    @(negedge clk) periph_req = 2'h1;
    @(negedge clk) periph_req = 2'h0;
    wait_wr(n0 + 1);
    trig(2'h1);
    wait_done(0);
    check("reload", 2, rem[31:0]);
    trig(2'h1);
    wait_wr(n0 + 3);
    check("reload addr", 32'h200, mem_u.wr_addr[n0 + 2]);
    ch_enable[0] = 1'b0;
    n0 = mem_u.n_wr;
    setup(0, 16'h0B40, 32'h1);
    periph_req = 2'h1;
    repeat (20) @(negedge clk);
    check("m2m", n0, mem_u.n_wr);
    periph_req = 2'h0;
    trig(2'h1);
    wait_done(0);
    gate = 1'b0;
    setup(1, 16'h0B00, 32'h1);
    trig(2'h2);
    repeat (20) @(negedge clk);
    check("gated", n0 + 1, mem_u.n_wr);
    check("busy", 0, busy);
    gate = 1'b1;
    wait_done(1);
    stop_test;
  end
endmodule // test_tcd_dma
